// >>> seq_pkg.sv
package seq_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_KHZ          = 125000;
    localparam int unsigned TRAIN_TIME_MS    = 20;
    localparam int unsigned RETRY_TIME_MS    = 100;
    localparam int unsigned EEPROM_TIME_MS   = 200;
    localparam int unsigned NORMAL_TIME_MS   = 1000;
    localparam int unsigned TRAIN_CYCLES     = TRAIN_TIME_MS * CLK_KHZ;
    localparam int unsigned RETRY_CYCLES     = RETRY_TIME_MS * CLK_KHZ;
    localparam int unsigned EEPROM_CYCLES    = EEPROM_TIME_MS * CLK_KHZ;
    localparam int unsigned NORMAL_CYCLES    = NORMAL_TIME_MS * CLK_KHZ;

    // Master bus rates, half period of its clock in core cycles
    localparam int unsigned SLOW_BUS_KHZ     = 100;
    localparam int unsigned FAST_BUS_KHZ     = 400;
    localparam logic [11:0] SLOW_HALF_PERIOD =
        12'(CLK_KHZ / (2 * SLOW_BUS_KHZ));
    localparam logic [11:0] FAST_HALF_PERIOD =
        12'(CLK_KHZ / (2 * FAST_BUS_KHZ));

    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [3:0] SWITCH_CONTROL_ADDR = 4'h0;
    localparam logic [3:0] SWITCH_STATUS_ADDR  = 4'h4;
    localparam logic [3:0] SMBUS_STATUS_ADDR   = 4'h8;
    localparam int unsigned FUNDAMENTAL_RESET_BIT_POS           = 0;
    localparam int unsigned HALT_POS           = 1;
    localparam int unsigned STATE_POS          = 16;
    localparam int unsigned ERR_CODE_POS       = 8;
    localparam logic [7:0] TIMEOUT_CODE        = 8'hff;

    // Switch modes
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_EEPROM = 4'h1;

    // Reset values
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [9:0] {
        ST_RESET_WAIT  = 10'h001,
        ST_CAPTURE     = 10'h002,
        ST_PLL_INIT    = 10'h004,
        ST_LINK_START  = 10'h008,
        ST_BUS_RATE    = 10'h010,
        ST_SLAVE_INIT  = 10'h020,
        ST_MASTER_INIT = 10'h040,
        ST_EEPROM_LOAD = 10'h080,
        ST_HALT        = 10'h100,
        ST_NORMAL      = 10'h200
    } state_t;

    typedef struct packed {
        logic [3:0] slave_addr;
        logic [3:0] mode;
        logic       halt_pin;
        logic       slow;
        logic       cclk_ds;
        logic       cclk_us;
    } boot_vec_t;

    typedef struct packed {
        logic      perst_n;
        boot_vec_t boot;
    } pins_t;

    localparam int unsigned PINS_W = $bits(pins_t);

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } av_req_t;

    typedef struct packed {
        logic [7:0] code;
        logic       error;
        logic       done;
    } eep_stat_t;

endpackage

// >>> pin_sync.sv
`timescale 1ns/1ps
module pin_sync
    import seq_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    // Pins and their synchronised copy
    input  wire logic [PINS_W-1:0] pin_async,
    output logic      [PINS_W-1:0] pin_sync_out
);

    typedef struct packed {
        logic [PINS_W-1:0] meta;
        logic [PINS_W-1:0] stable;
    } sync_t;

    sync_t r;
    sync_t next_r;

    // ------------------------------------------------------------
    // Two flip-flop synchroniser, two stages per bit
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        if (clk_en) begin
            next_r.meta   = pin_async;
            next_r.stable = r.meta;   // Only reader of the first stage
        end
    end

    // Reset level is asserted fundamental reset, pin low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign pin_sync_out = r.stable;

endmodule

// >>> switch_reset_init_sequencer.sv
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module switch_reset_init_sequencer
    import seq_pkg::*;
#(
    parameter logic [31:0] TRAIN_LIMIT  = TRAIN_CYCLES,
    parameter logic [31:0] RETRY_LIMIT  = RETRY_CYCLES,
    parameter logic [31:0] EEPROM_LIMIT = EEPROM_CYCLES,
    parameter logic [31:0] NORMAL_LIMIT = NORMAL_CYCLES
)
(
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // Avalon-MM slave
    input  wire av_req_t     av_req,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // Boot pins, asynchronous
    input  wire logic        fundamental_reset_n,
    input  wire logic        upstream_common_clock_pin,
    input  wire logic        downstream_common_clock_pin,
    input  wire logic        master_bus_slow_pin,
    input  wire logic        reset_halt,
    input  wire logic [3:0]  switch_op_mode,
    input  wire logic [3:0]  slave_bus_address_pins,
    // Clock generator and lane status
    input  wire logic        pll_serdes_ready,
    // EEPROM loader
    input  wire logic        eeprom_load_done,
    input  wire logic        eeprom_load_error,
    input  wire logic [7:0]  eeprom_error_code,
    output logic             eeprom_load_start,
    // Bring-up controls
    output logic             pll_serdes_init,
    output logic             link_train_en,
    output logic             stack_quasi_reset,
    output logic             config_retry_en,
    output logic             slave_bus_en,
    output logic [3:0]       slave_bus_addr,
    output logic             master_bus_en,
    output logic [11:0]      master_bus_half_period,
    output logic             upstream_common_clock,
    output logic             downstream_common_clock,
    output logic             ssc_allowed,
    output logic             gpio_force_input,
    output logic             core_reset_n,
    output logic             normal_op
);

    typedef struct packed {
        state_t      state;
        logic        sw_reset;
        logic        cold_seen;
        boot_vec_t   boot;
        boot_vec_t   cold_boot;
        logic        halt;
        logic        ack;
        logic [31:0] rdata;
        logic [31:0] elapsed;
        logic [31:0] eep_timer;
        logic        eep_start;
        eep_stat_t   eep;
    } seq_t;

    seq_t  r;
    seq_t  next_r;
    pins_t pins;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    pin_sync u_pin_sync (
        .clk          (clk),
        .reset_n      (reset_n),
        .clk_en       (clk_en),
        .pin_async    ({fundamental_reset_n, slave_bus_address_pins,
                        switch_op_mode, reset_halt, master_bus_slow_pin,
                        downstream_common_clock_pin,
                        upstream_common_clock_pin}),
        .pin_sync_out (pins)
    );

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    logic req;
    logic accept;
    logic fundamental_reset_bit_write;

    // One wait cycle per access; a frozen enable never completes one
    assign req         = av_req.read | av_req.write;
    assign waitrequest = req & ~(r.ack & clk_en);
    assign accept      = req & r.ack & clk_en;
    assign fundamental_reset_bit_write  = accept & av_req.write &
                         (av_req.address == SWITCH_CONTROL_ADDR) &
                         av_req.writedata[FUNDAMENTAL_RESET_BIT_POS];

    // ------------------------------------------------------------
    // Sequencer and registers
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        if (clk_en) begin
            next_r.eep_start = 1'b0;
            // Saturating time since the reset condition cleared
            if (r.elapsed != 32'hffff_ffff) begin
                next_r.elapsed = r.elapsed + 32'h1;
            end

            // Register access, set by hardware below wins over clear
            next_r.ack = req & ~r.ack;
            if (req & ~r.ack & av_req.read) begin
                if (av_req.address == SWITCH_CONTROL_ADDR) begin
                    next_r.rdata = DATA_RESET;
                    next_r.rdata[HALT_POS] = r.halt;
                end else if (av_req.address == SWITCH_STATUS_ADDR) begin
                    next_r.rdata = DATA_RESET;
                    next_r.rdata[$bits(boot_vec_t)-1:0] = r.cold_boot;
                    next_r.rdata[STATE_POS +: $bits(state_t)] = r.state;
                end else if (av_req.address == SMBUS_STATUS_ADDR) begin
                    next_r.rdata = DATA_RESET;
                    next_r.rdata[0] = r.eep.done;
                    next_r.rdata[1] = r.eep.error;
                    next_r.rdata[ERR_CODE_POS +: 8] = r.eep.code;
                end else begin
                    next_r.rdata = DATA_RESET; // Unmapped reads zero
                end
            end
            if (accept & av_req.write &
                (av_req.address == SWITCH_CONTROL_ADDR)) begin
                next_r.halt = av_req.writedata[HALT_POS];
            end

            case (r.state)
                ST_RESET_WAIT: begin
                    next_r.elapsed = '0;
                    if (pins.perst_n) begin
                        next_r.state = ST_CAPTURE;
                    end
                end
                ST_CAPTURE: begin
                    // Software reset keeps the previous vector
                    if (!r.sw_reset) begin
                        next_r.boot = pins.boot;
                        if (!r.cold_seen) begin
                            next_r.cold_boot = pins.boot;
                            next_r.cold_seen = 1'b1;
                        end
                    end
                    next_r.state = ST_PLL_INIT;
                end
                ST_PLL_INIT: begin
                    // A late PLL still gets training on time
                    if (pll_serdes_ready || r.elapsed >= TRAIN_LIMIT) begin
                        next_r.state = ST_LINK_START;
                    end
                end
                ST_LINK_START: begin
                    if (r.boot.halt_pin) begin
                        next_r.halt = 1'b1;
                    end
                    next_r.state = ST_BUS_RATE;
                end
                ST_BUS_RATE: begin
                    next_r.state = ST_SLAVE_INIT;
                end
                ST_SLAVE_INIT: begin
                    next_r.state = ST_MASTER_INIT;
                end
                ST_MASTER_INIT: begin
                    if (r.boot.mode == MODE_EEPROM) begin
                        next_r.state     = ST_EEPROM_LOAD;
                        next_r.eep_start = 1'b1;
                        next_r.eep_timer = '0;
                    end else begin
                        next_r.state = ST_HALT;
                    end
                end
                ST_EEPROM_LOAD: begin
                    // Loader writes land as they occur; no reordering here
                    next_r.eep_timer = r.eep_timer + 32'h1;
                    if (eeprom_load_error) begin
                        next_r.halt       = 1'b1;
                        next_r.eep.error  = 1'b1;
                        next_r.eep.code   = eeprom_error_code;
                        next_r.eep.done   = 1'b1;
                        next_r.state      = ST_HALT;
                    end else if (r.eep_timer >= EEPROM_LIMIT) begin
                        // Bound the load so normal start stays within 1 s
                        next_r.halt       = 1'b1;
                        next_r.eep.error  = 1'b1;
                        next_r.eep.code   = TIMEOUT_CODE;
                        next_r.eep.done   = 1'b1;
                        next_r.state      = ST_HALT;
                    end else if (eeprom_load_done) begin
                        next_r.eep.done = 1'b1;
                        next_r.state    = ST_HALT;
                    end
                end
                ST_HALT: begin
                    // Stay while the halt bit is set after any clear
                    if (!next_r.halt) begin
                        next_r.state = ST_NORMAL;
                    end
                end
                ST_NORMAL: begin
                    next_r.state = ST_NORMAL;
                end
                default: begin
                    next_r.state = ST_RESET_WAIT;
                end
            endcase

            // Reset sources: pin wins over a software request
            if (!pins.perst_n) begin
                next_r.state    = ST_RESET_WAIT;
                next_r.sw_reset = 1'b0;
            end else if (fundamental_reset_bit_write) begin
                next_r.state    = ST_RESET_WAIT;
                next_r.sw_reset = 1'b1;
            end
            if (next_r.state == ST_RESET_WAIT) begin
                next_r.halt = 1'b0;
                next_r.eep  = '0;
            end
        end
    end

    // Power-on starts a cold fundamental reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r       <= '0;
            r.state <= ST_RESET_WAIT;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic stacks_up;
    logic past_rate;

    // Reserved modes count as test modes: stacks stay held
    assign stacks_up = (r.boot.mode == MODE_NORMAL) |
                       (r.boot.mode == MODE_EEPROM);
    assign past_rate = r.state inside {ST_SLAVE_INIT, ST_MASTER_INIT,
                                       ST_EEPROM_LOAD, ST_HALT, ST_NORMAL};

    assign readdata               = r.rdata;
    assign eeprom_load_start      = r.eep_start;
    assign pll_serdes_init        = ~(r.state inside {ST_RESET_WAIT,
                                                      ST_CAPTURE});
    assign link_train_en          = past_rate |
                                    (r.state inside {ST_LINK_START,
                                                     ST_BUS_RATE});
    assign stack_quasi_reset      = link_train_en & stacks_up &
                                    (r.state != ST_NORMAL);
    assign config_retry_en        = stack_quasi_reset;
    assign slave_bus_en           = past_rate;
    assign slave_bus_addr         = r.boot.slave_addr;
    assign master_bus_en          = past_rate & (r.state != ST_SLAVE_INIT);
    assign master_bus_half_period = r.boot.slow ? SLOW_HALF_PERIOD
                                                : FAST_HALF_PERIOD;
    assign upstream_common_clock   = r.boot.cclk_us;
    assign downstream_common_clock = r.boot.cclk_ds;
    // Flag for the board; the system itself must turn spreading off
    assign ssc_allowed            = r.boot.cclk_us & r.boot.cclk_ds;
    assign gpio_force_input       = r.state inside {ST_RESET_WAIT,
                                                    ST_CAPTURE};
    assign core_reset_n           = (r.state == ST_NORMAL);
    assign normal_op              = (r.state == ST_NORMAL);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    boot_capture_a: assert property (
        r.boot != $past(r.boot) |-> $past(r.state) == ST_CAPTURE)
        else $error("boot vector changed outside capture");
    mode_eeprom_a: assert property (
        eeprom_load_start |-> r.boot.mode == MODE_EEPROM)
        else $error("eeprom load started in a non-eeprom mode");
    halt_hold_a: assert property (
        r.state == ST_HALT && r.halt && !accept && pins.perst_n
        |=> r.state == ST_HALT)
        else $error("left halt while halt bit set");
    halt_pin_a: assert property (
        clk_en && r.state == ST_LINK_START && r.boot.halt_pin
        && pins.perst_n && !fundamental_reset_bit_write |=> r.halt)
        else $error("halt pin did not set halt bit");
    fundamental_reset_bit_order_a: assert property (
        fundamental_reset_bit_write && r.state != ST_RESET_WAIT
        |-> !waitrequest ##1 r.state == ST_RESET_WAIT)
        else $error("reset began before write completed");
    train_time_a: assert property (
        r.state == ST_PLL_INIT |-> r.elapsed <= TRAIN_LIMIT)
        else $error("training request missed its deadline");
    retry_time_a: assert property (
        $rose(config_retry_en) |-> r.elapsed <= RETRY_LIMIT)
        else $error("config retry enabled too late");
    eeprom_err_a: assert property (
        clk_en && r.state == ST_EEPROM_LOAD && eeprom_load_error
        && pins.perst_n && !fundamental_reset_bit_write
        |=> r.halt && r.eep.error && r.eep.done && r.state == ST_HALT)
        else $error("eeprom error not recorded");
    halt_gate_a: assert property (
        r.state == ST_HALT |-> !core_reset_n && slave_bus_en
        && master_bus_en)
        else $error("halt did not hold core in reset");
    normal_time_a: assert property (
        r.state == ST_EEPROM_LOAD |-> r.elapsed <= NORMAL_LIMIT)
        else $error("eeprom load ran past start deadline");
    gpio_input_a: assert property (
        r.state == ST_RESET_WAIT |-> gpio_force_input && !normal_op)
        else $error("general pins not forced to input");

    normal_reached_c: cover property ($rose(normal_op));
    halt_entered_c:   cover property (r.state == ST_HALT && r.halt);
    eeprom_fail_c:    cover property ($rose(r.eep.error));
    sw_reset_c:       cover property (fundamental_reset_bit_write);

endmodule

// >>> init_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// Lane and loader model
// ----------------------------------------
module init_partner (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Requests from the sequencer, plus the bench's failure switch
    input  wire logic       pll_serdes_init,
    input  wire logic       eeprom_load_start,
    input  wire logic       fail,
    // Answers
    output logic            pll_serdes_ready,
    output logic            eeprom_load_done,
    output logic            eeprom_load_error,
    output logic [7:0]      eeprom_error_code
);
    logic [3:0] lane_cnt;
    logic [3:0] load_cnt;

    // Lanes lock six cycles after init, drop again on any reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            lane_cnt <= 4'h0;
        else if (!pll_serdes_init)
            lane_cnt <= 4'h0;
        else if (lane_cnt != 4'hf)
            lane_cnt <= lane_cnt + 4'h1;
    end
    assign pll_serdes_ready = lane_cnt >= 4'h6;

    // A load takes eight cycles, writes in order, then done or error
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            load_cnt <= 4'h0;
        else if (eeprom_load_start)
            load_cnt <= 4'h8;
        else if (load_cnt != 4'h0)
            load_cnt <= load_cnt - 4'h1;
    end
    assign eeprom_load_done  = load_cnt == 4'h1 && !fail;
    assign eeprom_load_error = load_cnt == 4'h1 && fail;
    // Code is only meaningful with error, so it is inverted otherwise
    assign eeprom_error_code = eeprom_load_error ? 8'h3c : 8'hc3;
endmodule

// >>> tb_switch_reset_init_sequencer.sv
`timescale 1ns/1ps
module tb_switch_reset_init_sequencer
    import seq_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        fundamental_reset_n = 1'b0;
    logic        fail = 1'b0;
    boot_vec_t   pins = 12'h000;
    av_req_t     req = '0;
    logic [31:0] readdata, rd;
    logic [11:0] master_bus_half_period;
    logic [7:0]  eeprom_error_code;
    logic [3:0]  slave_bus_addr;
    logic        waitrequest, pll_serdes_ready, eeprom_load_done;
    logic        eeprom_load_error, eeprom_load_start, pll_serdes_init;
    logic        link_train_en, stack_quasi_reset, config_retry_en;
    logic        slave_bus_en, master_bus_en, upstream_common_clock;
    logic        downstream_common_clock, ssc_allowed, gpio_force_input;
    logic        core_reset_n, normal_op;
    int          miscompares = 0;
    int          checks = 0;
    // Fast/both, slow/downstream, reserved mode, EEPROM mode
    boot_vec_t   rows [4] = '{12'h503, 12'h906, 12'hc21, 12'h315};

    always #4 clk = ~clk;

    // Short limits keep the run small
    switch_reset_init_sequencer #(.TRAIN_LIMIT(50), .RETRY_LIMIT(200),
        .EEPROM_LIMIT(100), .NORMAL_LIMIT(1000))
    switch_reset_init_sequencer_inst (.clk, .reset_n, .clk_en,
        .av_req(req), .readdata, .waitrequest, .fundamental_reset_n,
        .upstream_common_clock_pin(pins.cclk_us),
        .downstream_common_clock_pin(pins.cclk_ds),
        .master_bus_slow_pin(pins.slow), .reset_halt(pins.halt_pin),
        .switch_op_mode(pins.mode), .slave_bus_address_pins(pins.slave_addr),
        .pll_serdes_ready, .eeprom_load_done, .eeprom_load_error,
        .eeprom_error_code, .eeprom_load_start, .pll_serdes_init,
        .link_train_en, .stack_quasi_reset, .config_retry_en, .slave_bus_en,
        .slave_bus_addr, .master_bus_en, .master_bus_half_period,
        .upstream_common_clock, .downstream_common_clock, .ssc_allowed,
        .gpio_force_input, .core_reset_n, .normal_op);

    init_partner init_partner_inst (.clk, .reset_n, .pll_serdes_init,
        .eeprom_load_start, .fail, .pll_serdes_ready, .eeprom_load_done,
        .eeprom_load_error, .eeprom_error_code);

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Waitrequest is sampled at the very edge it qualifies
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        req <= '{read: !wr, write: wr, address: a, writedata: wd};
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        req <= '0;
    endtask

    // Bounded wait for training start or normal operation
    task automatic wait_hi(input bit link);
        repeat (2000) begin
            @(negedge clk);
            if ((link ? link_train_en : normal_op) === 1'b1)
                return;
        end
        miscompares++;
    endtask

    task automatic boot(input boot_vec_t b);
        @(posedge clk);
        fundamental_reset_n <= 1'b0;
        pins <= b;
        repeat (4) @(posedge clk);
        fundamental_reset_n <= 1'b1;
        wait_hi(1);
        chk("stack", b.mode < 4'h2, stack_quasi_reset);
        chk("retry", b.mode < 4'h2, config_retry_en);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        tally_and_finish;
    end

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            boot(rows[i]);
            wait_hi(0);
            chk("addr", rows[i].slave_addr, slave_bus_addr);
            chk("half", rows[i].slow ? SLOW_HALF_PERIOD : FAST_HALF_PERIOD,
                master_bus_half_period);
            chk("cclk", {rows[i].cclk_ds, rows[i].cclk_us},
                {downstream_common_clock, upstream_common_clock});
            chk("ssc", rows[i].cclk_ds & rows[i].cclk_us, ssc_allowed);
            chk("gpio", 0, gpio_force_input);
            chk("core", 1, core_reset_n);
            bus(0, SWITCH_STATUS_ADDR, 0);
            chk("cold", rows[0], rd[11:0]);
            bus(0, SMBUS_STATUS_ADDR, 0);
            chk("done", rows[i].mode == MODE_EEPROM, rd[0]);
            pins <= ~rows[i];
            repeat (6) @(negedge clk);
            chk("hold", rows[i].slave_addr, slave_bus_addr);
        end
        // Halt pin parks the sequence until software clears it
        boot(12'h50b);
        repeat (30) @(negedge clk);
        chk("halted", 0, normal_op);
        chk("buses", 2'b11, {slave_bus_en, master_bus_en});
        bus(0, SWITCH_CONTROL_ADDR, 0);
        chk("haltbit", 1, rd[HALT_POS]);
        bus(1, SWITCH_CONTROL_ADDR, 0);
        wait_hi(0);
        chk("resume", 1, normal_op);
        // Loader failure
        @(posedge clk);
        fail <= 1'b1;
        boot(12'h310);
        repeat (30) @(negedge clk);
        bus(0, SMBUS_STATUS_ADDR, 0);
        chk("smbus", 16'h3c03, rd[15:0]);
        bus(0, SWITCH_CONTROL_ADDR, 0);
        chk("errhalt", 2, rd[1:0]);
        fail <= 1'b0;
        bus(1, SWITCH_CONTROL_ADDR, 0);
        wait_hi(0);
        // Software reset completes first and keeps the old vector
        @(posedge clk);
        pins <= 12'h7f0;
        bus(1, SWITCH_CONTROL_ADDR, 1);
        @(negedge clk);
        chk("fundamental_reset_bit", 2'b10, {gpio_force_input, normal_op});
        wait_hi(0);
        chk("reuse", 4'h3, slave_bus_addr);
        bus(0, 4'hc, 0);
        chk("unmapped", 0, rd);
        // Frozen clock enable stalls the bus until it returns
        clk_en <= 1'b0;
        fork
            bus(0, SWITCH_STATUS_ADDR, 0);
            begin
                repeat (4) @(negedge clk);
                chk("frozen", 1, waitrequest);
                @(posedge clk);
                clk_en <= 1'b1;
            end
        join
        chk("state", ST_NORMAL, rd[25:16]);
        // Power-on reset mid-run, then a fresh cold capture
        pins    <= 12'h206;
        reset_n <= 1'b0;
        @(negedge clk);
        chk("rst", {2'b10, FAST_HALF_PERIOD},
            {gpio_force_input, normal_op, master_bus_half_period});
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        wait_hi(0);
        bus(0, SWITCH_STATUS_ADDR, 0);
        chk("recold", 12'h206, rd[11:0]);
        tally_and_finish;
    end
endmodule
